//--- verilog/adccfg_pkg.sv
package adccfg_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] ADCCFG_OFS_SKEW      = 8'h70; // Inter-core skew trim
    localparam logic [7:0] ADCCFG_OFS_ADVANCE   = 8'h71; // Divided clock advance
    localparam logic [7:0] ADCCFG_OFS_DIVIDER_SELECT_PIN    = 8'h72; // Clock divisor select
    localparam logic [7:0] ADCCFG_OFS_OUTDRV    = 8'h73; // Output driver and coding
    localparam logic [7:0] ADCCFG_OFS_DLL_WR    = 8'h74; // DLL range write port
    localparam logic [7:0] ADCCFG_OFS_DLL_RB    = 8'h75; // DLL range readback
    localparam logic [7:0] ADCCFG_OFS_TEST      = 8'hc0; // Test pattern control
    localparam logic [7:0] ADCCFG_OFS_W1_LO     = 8'hc2; // First custom word, low
    localparam logic [7:0] ADCCFG_OFS_W1_HI     = 8'hc3; // First custom word, high
    localparam logic [7:0] ADCCFG_OFS_W2_LO     = 8'hc4; // Second custom word, low
    localparam logic [7:0] ADCCFG_OFS_W2_HI     = 8'hc5; // Second custom word, high

    // ************************************************************
    // Reset values and field positions
    // ************************************************************
    localparam logic [7:0] ADCCFG_RST_BYTE      = 8'h00; // Power-up value of all bytes
    localparam int         ADCCFG_DLL_BIT       = 6;     // DLL range bit, 1 = slow
    localparam int         ADCCFG_TMODE_LSB     = 6;     // Test mode field low bit
    localparam int         ADCCFG_DRV_LSB       = 5;     // Driver field low bit

    // ************************************************************
    // Override codes of the 3-bit fields
    // ************************************************************
    localparam logic [2:0] ADCCFG_OVR_PIN       = 3'h0;  // Follow the pin
    localparam logic [2:0] ADCCFG_OVR_A         = 3'h1;  // Divide by 1 / LVDS 2mA / twos
    localparam logic [2:0] ADCCFG_OVR_B         = 3'h2;  // Divide by 2 / LVDS 3mA / gray
    localparam logic [2:0] ADCCFG_OVR_C         = 3'h4;  // Divide by 4 / LVCMOS / binary

    // ************************************************************
    // Test pattern codes and fixed words
    // ************************************************************
    localparam logic [3:0]  ADCCFG_PAT_OFF      = 4'h0;
    localparam logic [3:0]  ADCCFG_PAT_MID      = 4'h1;
    localparam logic [3:0]  ADCCFG_PAT_ONES     = 4'h2;
    localparam logic [3:0]  ADCCFG_PAT_ZEROS    = 4'h3;
    localparam logic [3:0]  ADCCFG_PAT_CHECK    = 4'h4;
    localparam logic [3:0]  ADCCFG_PAT_ONEZERO  = 4'h7;
    localparam logic [3:0]  ADCCFG_PAT_USER     = 4'h8;
    localparam logic [15:0] ADCCFG_WORD_MID     = 16'h8000;
    localparam logic [15:0] ADCCFG_WORD_ONES    = 16'hffff;
    localparam logic [15:0] ADCCFG_WORD_ZEROS   = 16'h0000;
    localparam logic [15:0] ADCCFG_WORD_CHK_A   = 16'haaaa;
    localparam logic [15:0] ADCCFG_WORD_CHK_B   = 16'h5555;
    localparam logic [1:0]  ADCCFG_TMODE_ALT    = 2'h1;  // Alternate mode value

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        ADCCFG_DIV1 = 2'b00,
        ADCCFG_DIV2 = 2'b01,
        ADCCFG_DIV4 = 2'b10
    } adccfg_div_type;

    typedef enum logic [1:0] {
        ADCCFG_LVDS_2MA = 2'b00,
        ADCCFG_LVDS_3MA = 2'b01,
        ADCCFG_LVCMOS   = 2'b10
    } adccfg_drv_type;

    typedef enum logic [1:0] {
        ADCCFG_TWOS   = 2'b00,
        ADCCFG_GRAY   = 2'b01,
        ADCCFG_OFFBIN = 2'b10
    } adccfg_code_type;

    typedef struct packed {
        logic [15:0] word1;   // First word of a pattern
        logic [15:0] word2;   // Second word of a pattern
    } adccfg_pair_type;

endpackage : adccfg_pkg

//--- verilog/adccfg_top.sv
`timescale 1ns/1ps
// How it works
// - Eight-bit skew trim, reset 00h, mid 80h
// - Phase advance pulls divide-by-four edge one cycle
// - Writing 0 then 1 to advance bit0
// - Divisor field: pin, by 1, 2, 4
// - Soft reset spares divisor and driver registers
// - Bits 7:5 pick pin, LVDS 2mA/3mA, LVCMOS
// - Bits 2:0 pick pin, twos, gray, binary
// - Bit 6 picks DLL range, fast by default
// - Alternate mode swaps words; static holds one
// - Pattern appears some sample clocks after enabling
// - Bits 7:6: static zero, alternate one
// - Pattern selector yields fixed and checkerboard words
// - Code 1000 sends user words; 0101/0110 reserved
// - User words built from low/high byte registers
// - Soft reset restores defaults except immune registers
module adccfg_top
    import adccfg_pkg::*;
(
    input  wire logic            i_clk,
    input  wire logic            i_reset_n,
    input  wire logic            i_clk_en,
    input  wire logic            i_soft_reset,
    input  wire logic            i_reg_wr,
    input  wire logic            i_reg_rd,
    input  wire logic [7:0]      i_reg_addr,
    input  wire logic [7:0]      i_reg_wdata,
    input  wire logic [1:0]      i_divider_select_pin,
    input  wire logic [1:0]      i_output_driver_pin,
    input  wire logic [1:0]      i_output_coding_pin,
    output logic      [7:0]      o_reg_rdata,
    output logic                 o_reg_rvalid,
    output logic      [7:0]      o_skew_trim,
    output adccfg_div_type       o_divisor,
    output logic                 o_div_clk,
    output logic                 o_div_edge,
    output adccfg_drv_type       o_drive,
    output adccfg_code_type      o_coding,
    output logic                 o_dll_slow,
    output logic                 o_test_active,
    output logic      [15:0]     o_test_word
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [5:0]      pin_raw;     // All tri-level pin codes side by side
    logic [5:0]      pin_s1_q;    // First stage, read only by second
    logic [5:0]      pin_s2_q;    // Second stage
    logic [5:0]      pin_s3_q;    // Third stage
    logic [5:0]      pin_q;       // Accepted pin value

    assign pin_raw = {i_output_coding_pin, i_output_driver_pin, i_divider_select_pin};

    // Each bit is accepted only once two late stages agree, to reject a glitch
    generate
        for (genvar b = 0; b < 6; b++) begin : g_pin_sync
            always_ff @(posedge i_clk) begin
                if (!i_reset_n) begin
                    pin_s1_q[b] <= 1'b0;
                    pin_s2_q[b] <= 1'b0;
                    pin_s3_q[b] <= 1'b0;
                    pin_q[b]    <= 1'b0;
                end else if (i_clk_en) begin
                    pin_s1_q[b] <= pin_raw[b];
                    pin_s2_q[b] <= pin_s1_q[b];
                    pin_s3_q[b] <= pin_s2_q[b];
                    if (pin_s2_q[b] == pin_s3_q[b]) begin
                        pin_q[b] <= pin_s3_q[b];
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // Register file
    // ************************************************************
    logic [7:0]      skew_q;      // Inter-core skew trim
    logic [7:0]      adv_q;       // Divided clock advance register
    logic [7:0]      divider_select_pin_q;    // Clock divisor select, soft reset immune
    logic [7:0]      outdrv_q;    // Output driver and coding, soft reset immune
    logic [7:0]      dll_wr_q;    // DLL range write port
    logic            dll_slow_q;  // DLL range state, 1 = slow
    logic [7:0]      test_q;      // Test pattern control
    adccfg_pair_type user_q;      // Custom words
    logic            adv_pulse_q; // One cycle per 0-to-1 on advance bit 0
    logic            wr_en;       // Write taken this cycle

    assign wr_en = i_clk_en && i_reg_wr;

    // Registers cleared by power-up reset and by soft reset
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            skew_q     <= ADCCFG_RST_BYTE;
            adv_q      <= ADCCFG_RST_BYTE;
            dll_wr_q   <= ADCCFG_RST_BYTE;
            dll_slow_q <= 1'b0;
            test_q     <= ADCCFG_RST_BYTE;
            user_q     <= '0;
        end else if (i_clk_en && i_soft_reset) begin
            // Soft reset wins over a write in the same cycle
            skew_q     <= ADCCFG_RST_BYTE;
            adv_q      <= ADCCFG_RST_BYTE;
            dll_wr_q   <= ADCCFG_RST_BYTE;
            dll_slow_q <= 1'b0;
            test_q     <= ADCCFG_RST_BYTE;
            user_q     <= '0;
        end else if (wr_en) begin
            case (i_reg_addr)
                ADCCFG_OFS_SKEW:    skew_q <= i_reg_wdata;
                ADCCFG_OFS_ADVANCE: adv_q  <= i_reg_wdata;
                ADCCFG_OFS_DLL_WR: begin
                    // New state = written ^ old write port ^ old state
                    dll_wr_q   <= i_reg_wdata;
                    dll_slow_q <= i_reg_wdata[ADCCFG_DLL_BIT] ^
                                  dll_wr_q[ADCCFG_DLL_BIT] ^ dll_slow_q;
                end
                ADCCFG_OFS_TEST:    test_q             <= i_reg_wdata;
                ADCCFG_OFS_W1_LO:   user_q.word1[7:0]  <= i_reg_wdata;
                ADCCFG_OFS_W1_HI:   user_q.word1[15:8] <= i_reg_wdata;
                ADCCFG_OFS_W2_LO:   user_q.word2[7:0]  <= i_reg_wdata;
                ADCCFG_OFS_W2_HI:   user_q.word2[15:8] <= i_reg_wdata;
                default: ;          // Other offsets belong elsewhere
            endcase
        end
    end

    // Registers immune to soft reset
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            divider_select_pin_q <= ADCCFG_RST_BYTE;
            outdrv_q <= ADCCFG_RST_BYTE;
        end else if (wr_en) begin
            // Soft reset is deliberately not looked at here
            if (i_reg_addr == ADCCFG_OFS_DIVIDER_SELECT_PIN) divider_select_pin_q <= i_reg_wdata;
            if (i_reg_addr == ADCCFG_OFS_OUTDRV) outdrv_q <= i_reg_wdata;
        end
    end

    // Advance command: the 0-to-1 step of bit 0 is the trigger
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            adv_pulse_q <= 1'b0;
        end else if (i_clk_en) begin
            adv_pulse_q <= wr_en && !i_soft_reset && (i_reg_addr == ADCCFG_OFS_ADVANCE)
                           && !adv_q[0] && i_reg_wdata[0];
        end
    end

    // Read data, one cycle after the request
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else if (i_clk_en) begin
            o_reg_rvalid <= i_reg_rd;
            case (i_reg_addr)
                ADCCFG_OFS_SKEW:    o_reg_rdata <= skew_q;
                ADCCFG_OFS_ADVANCE: o_reg_rdata <= adv_q;
                ADCCFG_OFS_DIVIDER_SELECT_PIN:  o_reg_rdata <= divider_select_pin_q;
                ADCCFG_OFS_OUTDRV:  o_reg_rdata <= outdrv_q;
                ADCCFG_OFS_DLL_WR:  o_reg_rdata <= dll_wr_q;
                ADCCFG_OFS_DLL_RB:  o_reg_rdata <= {1'b0, dll_slow_q,
                                                    6'h00};  // Range in force
                ADCCFG_OFS_TEST:    o_reg_rdata <= test_q;
                ADCCFG_OFS_W1_LO:   o_reg_rdata <= user_q.word1[7:0];
                ADCCFG_OFS_W1_HI:   o_reg_rdata <= user_q.word1[15:8];
                ADCCFG_OFS_W2_LO:   o_reg_rdata <= user_q.word2[7:0];
                ADCCFG_OFS_W2_HI:   o_reg_rdata <= user_q.word2[15:8];
                default:            o_reg_rdata <= 8'h00;   // Unmapped reads zero
            endcase
        end
    end

    assign o_skew_trim = skew_q;
    assign o_dll_slow  = dll_slow_q;

    // ************************************************************
    // Effective divisor, driver and coding selections
    // ************************************************************
    adccfg_div_type  div_q;   // Divisor in force
    adccfg_drv_type  drv_q;   // Driver in force
    adccfg_code_type code_q;  // Coding in force

    // Reserved codes, including pin code 11, keep the previous choice
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            div_q <= ADCCFG_DIV1;
        end else if (i_clk_en) begin
            case (divider_select_pin_q[2:0])
                ADCCFG_OVR_PIN: begin
                    if (pin_q[1:0] != 2'b11) div_q <= adccfg_div_type'(pin_q[1:0]);
                end
                ADCCFG_OVR_A: div_q <= ADCCFG_DIV1;
                ADCCFG_OVR_B: div_q <= ADCCFG_DIV2;
                ADCCFG_OVR_C: div_q <= ADCCFG_DIV4;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            drv_q <= ADCCFG_LVDS_2MA;
        end else if (i_clk_en) begin
            case (outdrv_q[ADCCFG_DRV_LSB +: 3])
                ADCCFG_OVR_PIN: begin
                    if (pin_q[3:2] != 2'b11) drv_q <= adccfg_drv_type'(pin_q[3:2]);
                end
                ADCCFG_OVR_A: drv_q <= ADCCFG_LVDS_2MA;
                ADCCFG_OVR_B: drv_q <= ADCCFG_LVDS_3MA;
                ADCCFG_OVR_C: drv_q <= ADCCFG_LVCMOS;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            code_q <= ADCCFG_TWOS;
        end else if (i_clk_en) begin
            case (outdrv_q[2:0])
                ADCCFG_OVR_PIN: begin
                    if (pin_q[5:4] != 2'b11) code_q <= adccfg_code_type'(pin_q[5:4]);
                end
                ADCCFG_OVR_A: code_q <= ADCCFG_TWOS;
                ADCCFG_OVR_B: code_q <= ADCCFG_GRAY;
                ADCCFG_OVR_C: code_q <= ADCCFG_OFFBIN;
                default: ;
            endcase
        end
    end

    assign o_divisor = div_q;
    assign o_drive   = drv_q;
    assign o_coding  = code_q;

    // ************************************************************
    // Clock divider with phase advance
    // ************************************************************
    logic [1:0] cnt_q;    // Phase within the divided period
    logic [1:0] cnt_d;

    // Skipping one phase state moves every later rising edge one cycle early
    always_comb begin
        case (div_q)
            ADCCFG_DIV2: cnt_d = {1'b0, ~cnt_q[0]};
            ADCCFG_DIV4: cnt_d = adv_pulse_q ? 2'(cnt_q + 2'd2) : 2'(cnt_q + 2'd1);
            default:     cnt_d = 2'd0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cnt_q      <= 2'd0;
            o_div_clk  <= 1'b0;
            o_div_edge <= 1'b0;
        end else if (i_clk_en) begin
            cnt_q      <= cnt_d;
            o_div_edge <= (cnt_d == 2'd0);
            o_div_clk  <= (div_q == ADCCFG_DIV1) || (div_q == ADCCFG_DIV2 && cnt_d == 2'd0)
                          || (div_q == ADCCFG_DIV4 && !cnt_d[1]);
        end
    end

    // ************************************************************
    // Test pattern generator
    // ************************************************************
    adccfg_pair_type pair;      // Words chosen by the selector
    logic            pat_on;    // Selector names a pattern
    logic            phase_q;   // Alternating phase of the sample clock
    logic            alt_mode;  // Alternate mode chosen

    assign alt_mode = (test_q[ADCCFG_TMODE_LSB +: 2] == ADCCFG_TMODE_ALT);

    // Single-word patterns repeat their word in alternate mode
    always_comb begin
        pat_on = 1'b1;
        case (test_q[3:0])
            ADCCFG_PAT_MID:     pair = '{ADCCFG_WORD_MID,   ADCCFG_WORD_MID};
            ADCCFG_PAT_ONES:    pair = '{ADCCFG_WORD_ONES,  ADCCFG_WORD_ONES};
            ADCCFG_PAT_ZEROS:   pair = '{ADCCFG_WORD_ZEROS, ADCCFG_WORD_ZEROS};
            ADCCFG_PAT_CHECK:   pair = '{ADCCFG_WORD_CHK_A, ADCCFG_WORD_CHK_B};
            ADCCFG_PAT_ONEZERO: pair = '{ADCCFG_WORD_ONES,  ADCCFG_WORD_ZEROS};
            ADCCFG_PAT_USER:    pair = user_q;
            default: begin
                // Off and reserved codes pass normal data
                pair   = '0;
                pat_on = 1'b0;
            end
        endcase
    end

    // Output is a clocked stage, so enabling shows up one cycle later
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            phase_q       <= 1'b0;
            o_test_active <= 1'b0;
            o_test_word   <= 16'h0000;
        end else if (i_clk_en) begin
            phase_q       <= alt_mode ? ~phase_q : 1'b0;
            o_test_active <= pat_on;
            o_test_word   <= (alt_mode && phase_q) ? pair.word2 : pair.word1;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    chk_skew_default: assert property ($past(!i_reset_n) |-> o_skew_trim == 8'h00)
        else $error("skew trim not cleared by reset");
    chk_adv_trigger: assert property (
        (wr_en && !i_soft_reset && i_reg_addr == ADCCFG_OFS_ADVANCE && !adv_q[0]
         && i_reg_wdata[0]) |=> adv_pulse_q)
        else $error("advance command not detected");
    chk_div4_advance: assert property (
        (i_clk_en && adv_pulse_q && div_q == ADCCFG_DIV4)
        |=> cnt_q == 2'($past(cnt_q) + 2'd2))
        else $error("advance did not skip one cycle");
    chk_div4_period: assert property (
        (i_clk_en && div_q == ADCCFG_DIV4 && !adv_pulse_q && $stable(div_q))
        |=> cnt_q == 2'($past(cnt_q) + 2'd1))
        else $error("divide by four period broken");
    chk_div_reserved: assert property (
        (i_clk_en && divider_select_pin_q[2:0] == 3'h3) |=> $stable(div_q))
        else $error("reserved divisor code changed divisor");
    chk_soft_immune: assert property (
        (i_soft_reset && !i_reg_wr) |=> $stable(divider_select_pin_q) && $stable(outdrv_q))
        else $error("soft reset disturbed immune register");
    chk_soft_clear: assert property ((i_clk_en && i_soft_reset)
        |=> skew_q == 8'h00 && test_q == 8'h00 && !dll_slow_q)
        else $error("soft reset left a register set");
    chk_dll_xor: assert property (
        (wr_en && !i_soft_reset && i_reg_addr == ADCCFG_OFS_DLL_WR)
        |=> dll_slow_q == ($past(i_reg_wdata[ADCCFG_DLL_BIT]) ^
            $past(dll_wr_q[ADCCFG_DLL_BIT]) ^ $past(dll_slow_q)))
        else $error("DLL range update wrong");
    chk_mid_word: assert property (
        (i_clk_en && test_q[3:0] == ADCCFG_PAT_MID) |=> o_test_word == 16'h8000)
        else $error("midscale word wrong");
    chk_alt_swap: assert property (
        (i_clk_en && alt_mode && phase_q && test_q[3:0] == ADCCFG_PAT_CHECK)
        |=> o_test_word == 16'h5555)
        else $error("alternate phase word wrong");

    cov_advance:  cover property (adv_pulse_q && div_q == ADCCFG_DIV4);
    cov_user_alt: cover property (alt_mode && test_q[3:0] == ADCCFG_PAT_USER && phase_q);
    cov_soft_rst: cover property (i_clk_en && i_soft_reset && divider_select_pin_q != 8'h00);

endmodule : adccfg_top

//--- bench/adccfg_host.sv
`timescale 1ns/1ps
// ****
// Register host model
// ****
module adccfg_host (
    input  wire logic       i_clk,    // Sample clock
    input  wire logic [7:0] i_rdata,  // Read data
    input  wire logic       i_rvalid, // Read answer
    output logic            o_wr,     // Write strobe
    output logic            o_rd,     // Read strobe
    output logic [7:0]      o_addr,   // Offset
    output logic [7:0]      o_wdata   // Write data
);
    // Quiet bus at time zero
    initial begin
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_addr  = 8'h00;
        o_wdata = 8'h00;
    end
    // Released lines invert, so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr    <= 1'b1;
        o_addr  <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
    endtask : wr
    // A missing answer reads as unknown
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_rd   <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rvalid ? i_rdata : 8'hxx;
    endtask : rd
    // Advance needs a low then a high on bit 0
    task automatic advance();
        wr(8'h71, 8'h00);
        wr(8'h71, 8'h01);
    endtask : advance
    // Range is set by xor of both reads with the wanted value
    task automatic set_dll(input logic [7:0] want);
        logic [7:0] a;
        logic [7:0] b;
        rd(8'h74, a);
        rd(8'h75, b);
        wr(8'h74, a ^ b ^ want);
    endtask : set_dll
endmodule : adccfg_host

//--- bench/adccfg_bench.sv
`timescale 1ns/1ps
// ****
// Bench
// ****
module adccfg_bench
    import adccfg_pkg::*;
;
    logic i_clk = 1'b0, i_reset_n = 1'b0, i_soft_reset = 1'b0, i_clk_en = 1'b1;
    logic [1:0] i_divider_select_pin = 2'h1, i_output_driver_pin = 2'h2;
    logic [1:0] i_output_coding_pin = 2'h1;
    logic i_reg_wr, i_reg_rd, o_reg_rvalid, o_div_clk, o_div_edge, o_dll_slow, o_test_active;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_skew_trim, r;
    logic [15:0] o_test_word, a, b;
    adccfg_div_type o_divisor;
    adccfg_drv_type o_drive;
    adccfg_code_type o_coding;
    int err_count = 0, cmp_count = 0, cyc = 0, last_edge = 0, t0, dll = 0, ed, ev, ef;
    int mem [256];                   // Register model
    int cs [5] = '{0, 1, 2, 4, 3};   // Override codes, last one unlisted
    always #10 i_clk = ~i_clk;       // 50 MHz
    adccfg_host h (.i_clk, .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid), .o_wr(i_reg_wr),
        .o_rd(i_reg_rd), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
    adccfg_top dut (.i_clk, .i_reset_n, .i_clk_en, .i_soft_reset, .i_reg_wr, .i_reg_rd,
        .i_reg_addr, .i_reg_wdata, .i_divider_select_pin, .i_output_driver_pin,
        .i_output_coding_pin, .o_reg_rdata, .o_reg_rvalid, .o_skew_trim, .o_divisor, .o_div_clk,
        .o_div_edge, .o_drive, .o_coding, .o_dll_slow, .o_test_active, .o_test_word);
    // Time of the latest divided-clock edge
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (o_div_edge === 1'b1) last_edge <= cyc;
    end
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic w(input logic [7:0] ad, input logic [7:0] d);
        h.wr(ad, d);
        mem[ad] = d;
    endtask : w
    task automatic rchk(input logic [7:0] ad);
        h.rd(ad, r);
        chk("rdata", r, 16'(mem[ad]));
    endtask : rchk
    task automatic settle();
        repeat (4) @(posedge i_clk);
        #1;
    endtask : settle
    // Unlisted codes keep the previous choice
    function automatic int sel(int c, int p, int prev);
        return (c == 0) ? p : (c == 1) ? 0 : (c == 2) ? 1 : (c == 4) ? 2 : prev;
    endfunction : sel
    // Word k of pattern c; single-word patterns repeat word 1
    function automatic logic [15:0] pw(int c, int k);
        case (c)
            1: return 16'h8000;
            2: return 16'hffff;
            4: return k ? 16'h5555 : 16'haaaa;
            7: return k ? 16'h0000 : 16'hffff;
            8: return 16'(k ? mem['hc5] << 8 | mem['hc4] : mem['hc3] << 8 | mem['hc2]);
            default: return 16'h0000;
        endcase
    endfunction : pw
    task automatic final_report();
        $display("errors %0d checks %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    initial begin
        void'($urandom(32'h2321ce9d));
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rchk(8'h70);
        w(8'h70, 8'($urandom));
        rchk(8'h70);
        chk("skew", o_skew_trim, 16'(mem['h70]));
        @(posedge i_clk);
        i_clk_en <= 1'b0;            // A write while frozen is lost
        h.wr(8'h70, ~8'(mem['h70]));
        i_clk_en <= 1'b1;
        rchk(8'h70);
        h.wr(8'h80, 8'h5a);
        rchk(8'h80);
        rchk(8'h75);
        for (int i = 0; i < 2; i++) begin
            t0 = mem['h74] ^ (dll << 6) ^ (i ? 0 : 'h40);
            h.set_dll(i ? 8'h00 : 8'h40);
            mem['h74] = t0;
            dll = 1 - i;
            settle();
            chk("dll", o_dll_slow, 16'(dll));
            h.rd(8'h75, r);
            chk("readback", r, 16'(dll << 6));
        end
        foreach (cs[i]) begin
            w(8'h72, 8'(cs[i]));
            w(8'h73, 8'(cs[i] << 5 | cs[i]));
            settle();
            ed = sel(cs[i], 1, ed);
            ev = sel(cs[i], 2, ev);
            ef = sel(cs[i], 1, ef);
            chk("divisor", o_divisor, 16'(ed));
            chk("drive", o_drive, 16'(ev));
            chk("coding", o_coding, 16'(ef));
        end
        // Divide by four holds, since the unlisted code kept it
        t0 = last_edge;
        h.advance();
        repeat (12) @(posedge i_clk);
        chk("phase", 16'((last_edge - t0) % 4), 16'h3);
        w(8'h71, 8'h01);
        repeat (12) @(posedge i_clk);
        chk("phase", 16'((last_edge - t0) % 4), 16'h3);
        // Divided clock is high for the two cycles from its rising edge
        @(posedge i_clk iff o_div_edge === 1'b1);
        #1;
        chk("divclk", o_div_clk, 16'h1);
        @(posedge i_clk);
        #1;
        chk("divclk", o_div_clk, 16'h0);
        for (int k = 0; k < 4; k++) w(8'(8'hc2 + k), 8'($urandom));
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 9; c++) begin
                w(8'hc0, 8'(m << 6 | c));
                settle();
                a = o_test_word;
                @(posedge i_clk);
                #1 b = o_test_word;
                chk("active", o_test_active, 16'(c inside {1, 2, 3, 4, 7, 8}));
                t0 = (a === pw(c, 0) && b === pw(c, m)) || (b === pw(c, 0) && a === pw(c, m));
                chk("word", 16'(t0), 16'h1);
            end
        end
        @(posedge i_clk);
        i_soft_reset <= 1'b1;
        @(posedge i_clk);
        i_soft_reset <= 1'b0;
        foreach (mem[i]) if (i != 'h72 && i != 'h73) mem[i] = 0;
        settle();
        foreach (cs[i]) rchk(8'(8'h70 + cs[i]));
        rchk(8'hc3);
        chk("divisor", o_divisor, 16'h2);
        final_report();
    end
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge i_clk);
        err_count++;
        final_report();
    end
endmodule : adccfg_bench
